// ==== rtl/cbs_pkg.sv ====
package cbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry and register offsets
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_SYS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_STALL_REL = 8'h04;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Control register bit positions
  localparam int BIT_TRANS_EN = 0;
  localparam int BIT_ABORT_EN = 5;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_STALL_SEL = 7;
  localparam int BIT_PRIV_ASID = 12;
  localparam int BIT_TYPE_SEL = 20;
  localparam int BIT_USER_CMO = 30;
  localparam int FLD_TRANSIENT_LO = 14;
  localparam int FLD_BYPASS_MEM_ATTR_LO = 16;
  localparam int FLD_SHARE_LO = 22;
  localparam int FLD_RALLOC_LO = 24;
  localparam int FLD_WALLOC_LO = 26;
  localparam int FLD_SECURE_LO = 28;

  // Stall release bit and status register bits
  localparam int BIT_TNR = 0;
  localparam int BIT_ST_STALLED = 0;
  localparam int BIT_ST_SEC = 1;
  localparam int BIT_ST_STAGE2 = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and storage masks
  localparam logic [31:0] SYS_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] SYS_CTRL_IMPL_MASK = 32'h7FDFD0E1;
  localparam logic [31:0] SECURE_FIELD_MASK = 32'h30000000;
  localparam logic [31:0] TRANSIENT_FIELD_MASK = 32'h0000C000;
  // Fields the downstream bus can carry; clear a bit to make it read zero
  localparam logic [31:0] DOWNSTREAM_MASK = 32'hFFFFFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Implementation options
  localparam bit STALL_IMPL = 1'b1;
  localparam bit TRANSIENT_IMPL = 1'b1;
  localparam bit ATTR_WR_RETRY = 1'b1;
  localparam bit BANK_COUNT_RETRY = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Attribute codes
  localparam logic [1:0] ATTR_DEFAULT = 2'h0;
  localparam logic [1:0] ATTR_RSVD = 2'h1;
  localparam logic [3:0] BYPASS_MEM_ATTR_DEFAULT = 4'h0;

  typedef enum logic [1:0] {
    CBS_IDLE = 2'b00,
    CBS_STALLED = 2'b01,
    CBS_RETRY = 2'b10,
    CBS_TERM = 2'b11
  } cbs_state_e;

  // Context fault from the translation pipeline
  typedef struct packed {
    logic valid;
    logic stage2;
    logic sec_state;
  } cbs_fault_s;

  // Resume command to the translation pipeline
  typedef struct packed {
    logic retry;
    logic terminate;
    logic from_stage1;
    logic sec_state;
  } cbs_resume_s;

  // Attributes applied when translation is off
  typedef struct packed {
    logic active;
    logic [1:0] secure;
    logic [1:0] walloc;
    logic [1:0] ralloc;
    logic [1:0] share;
    logic type_sel;
    logic [3:0] mem_attr;
    logic [1:0] transient;
  } cbs_bypass_s;

endpackage

// ==== rtl/cbs_attr_field.sv ====
`timescale 1ns/1ps
module cbs_attr_field
  import cbs_pkg::*;
#(
  parameter bit HAS_RESERVED = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Field and bypass state
  input wire logic bypass_i,
  input wire logic [1:0] field_i,
  // Resolved attribute code
  output logic [1:0] code_o
);

  // Reserved code falls back to default rather than passing odd markings on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_o <= ATTR_DEFAULT;
    end else if (!bypass_i || (HAS_RESERVED && field_i == ATTR_RSVD)) begin
      code_o <= ATTR_DEFAULT;
    end else begin
      code_o <= field_i;
    end
  end

endmodule

// ==== rtl/cbs_ctrl.sv ====
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cbs_ctrl
  import cbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Translation pipeline side
  input wire cbs_fault_s fault_i,
  input wire logic fault_status_pending_i,
  input wire logic bank_attr_wr_i,
  input wire logic secure_bank_count_chg_i,
  input wire logic bank_is_secure_i,
  input wire logic wide_va_select_i,
  input wire logic [7:0] vmid_i,
  // Resume and fault responses
  output cbs_resume_s resume_o,
  output logic stalled_o,
  output logic fault_term_o,
  output logic fault_abort_o,
  output logic fault_irq_req_o,
  output logic repeat_fault_o,
  // Translation controls
  output logic translation_en_o,
  output logic user_cmo_en_o,
  output logic private_asid_o,
  output logic [7:0] asid_scope_vmid_o,
  output cbs_bypass_s bypass_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] sys_ctrl;
  logic [31:0] next_sys_ctrl;
  logic [31:0] lane_mask;
  logic [31:0] store_mask;
  cbs_state_e state;
  logic held_stage2;
  logic held_sec;
  logic bus_req;
  logic ctrl_wr;
  logic rel_wr;
  logic rel_accept;
  logic auto_retry;
  logic take_stall;
  logic bypass_on;
  logic bypass_active_q;
  logic type_sel_q;
  logic [3:0] mem_attr_q;
  logic [1:0] sec_code;
  logic [1:0] walloc_code;
  logic [1:0] ralloc_code;
  logic [1:0] share_code;
  logic [1:0] trans_code;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; one access per handshake because ack masks the request
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrl_wr = bus_req && wb_we_i && (wb_adr_i == OFS_SYS_CTRL);
  assign rel_wr = bus_req && wb_we_i && (wb_adr_i == OFS_STALL_REL) && wb_sel_i[0];
  // Only a real stall can be released
  assign rel_accept = rel_wr && STALL_IMPL && (state == CBS_STALLED);
  // Optional retry on bank attribute or secure bank count change
  assign auto_retry = (bank_attr_wr_i && ATTR_WR_RETRY) ||
                      (secure_bank_count_chg_i && BANK_COUNT_RETRY);
  assign take_stall = fault_i.valid && sys_ctrl[BIT_STALL_SEL] && STALL_IMPL;
  assign bypass_on = !sys_ctrl[BIT_TRANS_EN];

  // Byte lanes and storage mask for control writes
  always_comb begin
    lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    store_mask = SYS_CTRL_IMPL_MASK & DOWNSTREAM_MASK;
    if (!bank_is_secure_i) begin
      store_mask = store_mask & ~SECURE_FIELD_MASK;
    end
    if (!TRANSIENT_IMPL) begin
      store_mask = store_mask & ~TRANSIENT_FIELD_MASK;
    end
    next_sys_ctrl = ((sys_ctrl & ~lane_mask) | (wb_dat_i & lane_mask)) & store_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; all fields cleared so control state is defined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_ctrl <= SYS_CTRL_RESET;
    end else if (ctrl_wr) begin
      sys_ctrl <= next_sys_ctrl;
    end else if (!bank_is_secure_i) begin
      // Bank handed back to non-secure side drops the security field
      sys_ctrl <= sys_ctrl & ~SECURE_FIELD_MASK;
    end
  end

  // Bus answer: one wait state, unmapped reads zero, unmapped writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data; stall release is write-only and reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_SYS_CTRL: wb_dat_o <= sys_ctrl;
        OFS_STALL_REL: wb_dat_o <= 32'h00000000;
        OFS_STATUS: begin
          wb_dat_o <= 32'h00000000;
          wb_dat_o[BIT_ST_STALLED] <= (state == CBS_STALLED);
          wb_dat_o[BIT_ST_SEC] <= held_sec;
          wb_dat_o[BIT_ST_STAGE2] <= held_stage2;
        end
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall state; the mode bit is not consulted while stalled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CBS_IDLE;
    end else begin
      case (state)
        CBS_IDLE: begin
          if (take_stall) begin
            state <= CBS_STALLED;
          end
        end
        CBS_STALLED: begin
          if (rel_accept) begin
            state <= wb_dat_i[BIT_TNR] ? CBS_TERM : CBS_RETRY;
          end else if (auto_retry) begin
            state <= CBS_RETRY;
          end else begin
            state <= CBS_STALLED;
          end
        end
        CBS_RETRY: state <= CBS_IDLE;
        CBS_TERM: state <= CBS_IDLE;
        default: state <= CBS_IDLE;
      endcase
    end
  end

  // Security state and stage captured at the stall, frozen until resume
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_stage2 <= 1'b0;
      held_sec <= 1'b0;
    end else if (state == CBS_IDLE && take_stall) begin
      held_stage2 <= fault_i.stage2;
      held_sec <= fault_i.sec_state;
    end
  end

  // Resume command; restarting at the translation control step means any
  // translation control change made while stalled is picked up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_o <= '0;
    end else begin
      resume_o.retry <= (state == CBS_STALLED) && !(rel_accept && wb_dat_i[BIT_TNR]) &&
                        (rel_accept || auto_retry);
      resume_o.terminate <= rel_accept && wb_dat_i[BIT_TNR];
      // Only a retry restarts; a terminated transaction never re-enters stage 1
      resume_o.from_stage1 <= (state == CBS_STALLED) && !(rel_accept && wb_dat_i[BIT_TNR]) &&
                              (rel_accept || auto_retry);
      resume_o.sec_state <= held_sec;
    end
  end

  // Stalled flag mirrors the state for the fault status logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stalled_o <= 1'b0;
    end else begin
      stalled_o <= (state == CBS_IDLE) ? take_stall :
                   (state == CBS_STALLED) ? !(rel_accept || auto_retry) : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault responses; a fault during a stall is terminated since one slot only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_term_o <= 1'b0;
      fault_abort_o <= 1'b0;
      fault_irq_req_o <= 1'b0;
    end else begin
      fault_term_o <= fault_i.valid && !(take_stall && state == CBS_IDLE);
      fault_abort_o <= sys_ctrl[BIT_ABORT_EN] &&
                       ((fault_i.valid && !(take_stall && state == CBS_IDLE)) ||
                        (rel_accept && wb_dat_i[BIT_TNR]));
      fault_irq_req_o <= fault_i.valid && sys_ctrl[BIT_IRQ_EN];
    end
  end

  // Resume with fault status still set refaults the transaction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      repeat_fault_o <= 1'b0;
    end else begin
      repeat_fault_o <= rel_accept && fault_status_pending_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translation controls; user cache ops hold regardless of translation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      translation_en_o <= 1'b0;
      user_cmo_en_o <= 1'b0;
      private_asid_o <= 1'b0;
      asid_scope_vmid_o <= 8'h00;
      bypass_active_q <= 1'b1; // Control clears to translation off
    end else begin
      translation_en_o <= sys_ctrl[BIT_TRANS_EN];
      user_cmo_en_o <= wide_va_select_i && sys_ctrl[BIT_USER_CMO];
      private_asid_o <= sys_ctrl[BIT_PRIV_ASID];
      asid_scope_vmid_o <= vmid_i;
      bypass_active_q <= bypass_on;
    end
  end

  // Memory type overlay only when selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      type_sel_q <= 1'b0;
      mem_attr_q <= BYPASS_MEM_ATTR_DEFAULT;
    end else if (bypass_on && sys_ctrl[BIT_TYPE_SEL]) begin
      type_sel_q <= 1'b1;
      mem_attr_q <= sys_ctrl[FLD_BYPASS_MEM_ATTR_LO +: 4];
    end else begin
      type_sel_q <= 1'b0;
      mem_attr_q <= BYPASS_MEM_ATTR_DEFAULT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-bit bypass attribute fields
  cbs_attr_field #(.HAS_RESERVED(1'b1)) u_sec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(bypass_on),
    .field_i(sys_ctrl[FLD_SECURE_LO +: 2]),
    .code_o(sec_code)
  );

  cbs_attr_field #(.HAS_RESERVED(1'b1)) u_walloc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(bypass_on),
    .field_i(sys_ctrl[FLD_WALLOC_LO +: 2]),
    .code_o(walloc_code)
  );

  cbs_attr_field #(.HAS_RESERVED(1'b1)) u_ralloc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(bypass_on),
    .field_i(sys_ctrl[FLD_RALLOC_LO +: 2]),
    .code_o(ralloc_code)
  );

  // Every shareability code is meaningful
  cbs_attr_field #(.HAS_RESERVED(1'b0)) u_share (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(bypass_on),
    .field_i(sys_ctrl[FLD_SHARE_LO +: 2]),
    .code_o(share_code)
  );

  cbs_attr_field #(.HAS_RESERVED(1'b1)) u_trans (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(bypass_on),
    .field_i(sys_ctrl[FLD_TRANSIENT_LO +: 2]),
    .code_o(trans_code)
  );

  assign bypass_o = '{
    active: bypass_active_q,
    secure: sec_code,
    walloc: walloc_code,
    ralloc: ralloc_code,
    share: share_code,
    type_sel: type_sel_q,
    mem_attr: mem_attr_q,
    transient: trans_code
  };

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rel_retry;
    (state == CBS_STALLED) && rel_wr && !wb_dat_i[BIT_TNR];
  endsequence

  sequence s_rel_term;
    (state == CBS_STALLED) && rel_wr && wb_dat_i[BIT_TNR];
  endsequence

  property p_ignore_release;
    rel_wr && (state != CBS_STALLED) |=> !resume_o.retry && !resume_o.terminate;
  endproperty
  a_ignore_release: assert property (p_ignore_release)
    else $error("release write acted with no stall");

  property p_retry_release;
    s_rel_retry |=> resume_o.retry && !resume_o.terminate && resume_o.from_stage1
      && !stalled_o ##1 !resume_o.retry && (state == CBS_IDLE);
  endproperty
  a_retry_release: assert property (p_retry_release)
    else $error("retry release did not retry once");

  property p_term_release;
    s_rel_term |=> resume_o.terminate && !resume_o.retry && !resume_o.from_stage1
      ##1 !resume_o.terminate;
  endproperty
  a_term_release: assert property (p_term_release)
    else $error("terminate release did not terminate once");

  property p_sec_kept;
    (state == CBS_STALLED) && $past(state == CBS_STALLED) |-> $stable(held_sec);
  endproperty
  a_sec_kept: assert property (p_sec_kept)
    else $error("security state changed while stalled");

  property p_stall_kept;
    (state == CBS_STALLED) && !rel_wr && !auto_retry |=> stalled_o && (state == CBS_STALLED);
  endproperty
  a_stall_kept: assert property (p_stall_kept)
    else $error("stalled flag dropped without release");

  property p_ctrl_reset;
    $past(rst_i) |-> sys_ctrl[BIT_ABORT_EN] == 1'b0 && sys_ctrl[BIT_IRQ_EN] == 1'b0;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("fault enables not clear after reset");

  property p_bypass_secure;
    bypass_on && !ctrl_wr ##1 bypass_on |-> bypass_o.secure == $past(sys_ctrl[29:28] == ATTR_RSVD
      ? ATTR_DEFAULT : sys_ctrl[29:28]);
  endproperty
  a_bypass_secure: assert property (p_bypass_secure)
    else $error("bypass security code wrong");

  property p_bypass_share;
    bypass_on |=> bypass_o.share == $past(sys_ctrl[23:22]);
  endproperty
  a_bypass_share: assert property (p_bypass_share)
    else $error("bypass shareability wrong");

  property p_user_cmo;
    1'b1 |=> user_cmo_en_o == $past(wide_va_select_i && sys_ctrl[BIT_USER_CMO]);
  endproperty
  a_user_cmo: assert property (p_user_cmo)
    else $error("user cache op enable wrong");

  property p_repeat_fault;
    rel_accept && fault_status_pending_i |=> repeat_fault_o;
  endproperty
  a_repeat_fault: assert property (p_repeat_fault)
    else $error("resume with pending status did not refault");

endmodule

// ==== testbench/cbs_ctrl_tb.sv ====
`timescale 1ns/1ps
module cbs_ctrl_tb import cbs_pkg::*;;
  // Clock, reset and bus master signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  // Pipeline side stimulus
  cbs_fault_s fault = '0;
  logic pending = 1'b0;
  logic attr_wr = 1'b0;
  logic cnt_chg = 1'b0;
  logic bank_sec = 1'b0;
  logic wide_va = 1'b0;
  logic [7:0] vmid = 8'h5A;
  // Observed outputs
  cbs_resume_s resume;
  cbs_bypass_s byp;
  logic stalled, term, abrt, irq, rep, ten, ucmo, pasid;
  logic [7:0] scope;
  // Scoreboard
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [6:0] snap;
  logic [3:0] fsnap;

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  cbs_ctrl u_cbs_ctrl (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fault_i(fault), .fault_status_pending_i(pending), .bank_attr_wr_i(attr_wr),
    .secure_bank_count_chg_i(cnt_chg), .bank_is_secure_i(bank_sec),
    .wide_va_select_i(wide_va), .vmid_i(vmid),
    .resume_o(resume), .stalled_o(stalled), .fault_term_o(term),
    .fault_abort_o(abrt), .fault_irq_req_o(irq), .repeat_fault_o(rep),
    .translation_en_o(ten), .user_cmo_en_o(ucmo), .private_asid_o(pasid),
    .asid_scope_vmid_o(scope), .bypass_o(byp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and end-of-test report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // Classic single cycle; pulse outputs are captured at the ack edge
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      $display("MISMATCH wb_ack_o expected 1 seen none");
      error_cnt++;
      print_verdict();
    end
    rd = rdat;
    snap = {resume, abrt, rep, stalled};
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // One-cycle fault pulse; responses land one cycle later
  task automatic hit(input logic st2, input logic sec);
    @(posedge clk_i);
    fault <= {1'b1, st2, sec};
    @(posedge clk_i);
    fault <= '0;
    @(posedge clk_i);
    fsnap = {term, abrt, irq, stalled};
  endtask

  // Attribute write or bank count change pulse
  task automatic kick(input logic which);
    @(posedge clk_i);
    attr_wr <= which;
    cnt_chg <= ~which;
    @(posedge clk_i);
    attr_wr <= 1'b0;
    cnt_chg <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [1:0] k;
    cbs_bypass_s e;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, write-only and unmapped reads
    bus(1'b0, OFS_SYS_CTRL, 32'h0, 4'hF);
    check("ctrl reset", SYS_CTRL_RESET, rd);
    bus(1'b0, OFS_STALL_REL, 32'h0, 4'hF);
    check("release read", 32'h0, rd);
    bus(1'b0, 8'hFC, 32'h0, 4'hF);
    check("unmapped read", 32'h0, rd);
    done("reset");
    // All ones in a non-secure bank; bit 30 needs wide VA
    bus(1'b1, OFS_SYS_CTRL, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, OFS_SYS_CTRL, 32'h0, 4'hF);
    check("ctrl readback", SYS_CTRL_IMPL_MASK & DOWNSTREAM_MASK & ~SECURE_FIELD_MASK, rd);
    check("user_cmo_en_o", 32'h0, {31'h0, ucmo});
    wide_va <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("user_cmo_en_o", 32'h1, {31'h0, ucmo});
    check("translation_en_o", 32'h1, {31'h0, ten});
    check("bypass_o off", 32'h0, {16'h0, byp});
    check("private_asid_o", 32'h1, {31'h0, pasid});
    check("asid_scope_vmid_o", 32'h5A, {24'h0, scope});
    done("control");
    // Every code of every two-bit bypass field, translation off, secure bank
    bank_sec <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      v = 32'h0;
      v[29:28] = k;
      v[27:26] = k;
      v[25:24] = k;
      v[23:22] = k;
      v[15:14] = k;
      v[20] = k[0];
      v[19:16] = k[0] ? {k, k} : 4'h0;
      bus(1'b1, OFS_SYS_CTRL, v, 4'hF);
      repeat (2) @(posedge clk_i);
      e.active = 1'b1;
      e.secure = (k == ATTR_RSVD) ? ATTR_DEFAULT : k;
      e.walloc = e.secure;
      e.ralloc = e.secure;
      e.share = k;
      e.type_sel = k[0];
      e.mem_attr = v[19:16];
      e.transient = e.secure;
      check("bypass_o", {16'h0, e}, {16'h0, byp});
    end
    done("bypass");
    // Stall in stage 2, then switch to terminate mode while stalled
    bus(1'b1, OFS_SYS_CTRL, 32'h000000E0, 4'hF);
    hit(1'b1, 1'b1);
    check("stall response", 32'h3, {28'h0, fsnap});
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    check("status", 32'h7, rd);
    bus(1'b1, OFS_SYS_CTRL, 32'h00000060, 4'hF);
    bus(1'b1, OFS_STALL_REL, 32'h0, 4'hE);
    check("stalled_o", 32'h1, {31'h0, stalled});
    bus(1'b1, OFS_STALL_REL, 32'hFFFFFFFF, 4'hF);
    check("terminate", 32'h2C, {25'h0, snap});
    done("terminate");
    // Retry from stage 1 while fault status still pending
    bus(1'b1, OFS_SYS_CTRL, 32'h00000080, 4'hF);
    hit(1'b1, 1'b0);
    pending <= 1'b1;
    bus(1'b1, OFS_STALL_REL, 32'h0, 4'hF);
    check("retry", 32'h52, {25'h0, snap});
    pending <= 1'b0;
    bus(1'b1, OFS_STALL_REL, 32'h0, 4'hF);
    check("idle release", 32'h0, {30'h0, snap[6:5]});
    done("retry");
    // Automatic retry on attribute write and bank count change
    hit(1'b0, 1'b1);
    check("stall response", 32'h1, {28'h0, fsnap});
    kick(1'b1);
    check("stalled_o", 32'h0, {31'h0, stalled});
    hit(1'b0, 1'b1);
    check("stall response", 32'h1, {28'h0, fsnap});
    kick(1'b0);
    check("stalled_o", 32'h0, {31'h0, stalled});
    done("auto retry");
    // Terminate mode with abort enabled
    bus(1'b1, OFS_SYS_CTRL, 32'h00000020, 4'hF);
    hit(1'b0, 1'b0);
    check("terminate response", 32'hC, {28'h0, fsnap});
    done("immediate");
    print_verdict();
  end
endmodule
